// file: rtp_binary_to_decimal_converter.sv
// Binary-to-decimal conversion register, 12-bit in, four BCD digits out.
// Assumes a one-cycle write strobe from logic on mclk.
`timescale 1ns/1ps
`include "rtp_regs.svh"
module rtp_binary_to_decimal_converter
    import rtp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Write side
    input wire logic wr,
    input wire logic [11:0] binValue,
    // Read side
    output logic [15:0] bcdValue
);
    rtpB2bState_t st_ff;
    rtpB2bState_t nxt_st;

    // Shift-and-add-three, fully unrolled in one cycle
    function automatic logic [15:0] toBcd(input logic [11:0] bin);
        logic [27:0] sh;
        sh = {16'h0000, bin};
        for (int i = 0; i < 12; i++)
        begin
            for (int d = 0; d < 4; d++)
            begin
                if (sh[12 + 4 * d +: 4] > 4'h4)
                    sh[12 + 4 * d +: 4] = sh[12 + 4 * d +: 4] + 4'h3;
            end
            sh = sh << 1;
        end
        return sh[27:12];
    endfunction

    always_comb
    begin
        nxt_st = st_ff;
        if (wr)
            nxt_st.bcd = toBcd(binValue);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign bcdValue = st_ff.bcd;
endmodule

// file: rtp_pkg.sv
// Types shared by the prescale timer block.
// Assumes rtp_regs.svh is on the include path.
package rtp_pkg;
`include "rtp_regs.svh"
typedef struct packed {
    logic awvalid;
    logic [`RTP_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`RTP_AW-1:0] araddr;
    logic rready;
} rtpAxiReq_t;
typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
} rtpAxiRsp_t;
typedef struct packed {
    logic clockReady;
    logic intervalEvt;
    logic userAlarm;
    logic oscFail;
} rtpSrcEvt_t;
typedef struct packed {
    logic [2:0] sel;
    logic ie;
    logic fg;
} rtpTickCfg_t;
typedef struct packed {
    logic [7:0] cnt;
    logic evt;
} rtpPreState_t;
typedef struct packed {
    logic [15:0] bcd;
} rtpB2bState_t;
typedef struct packed {
    rtpAxiRsp_t rsp;
    logic awHave;
    logic [`RTP_AW-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [`RTP_ST_W-1:0] flag;
    logic [`RTP_ST_W-1:0] en;
    logic [`RTP_NTIMER-1:0][2:0] sel;
    rtpTickCfg_t [`RTP_NTIMER-1:0] rtn;
    logic hold;
    logic sleepPrev;
    logic irq;
    logic wake;
} rtpState_t;
endpackage

// file: rtp_prescale_timers.sv
// Prescale timers, interrupt vector and binary-to-decimal register on an AXI4-Lite slave.
// Assumes tick, source events and low-power levels come from logic on mclk.
`timescale 1ns/1ps
`include "rtp_regs.svh"

// Summary of operation
// - Timer 0 interval divides by 2^(code+1).
// - Timer 1 interval field in bits 4-2.
// - Bit 1 enables each timer's interrupt.
// - Bit 0 flag set on interval event.
// - Timer 1 enable also enables deep-sleep wake.
// - Timer 1 flag event wakes from deep sleep.
// - Settings held across deep sleep until unlock.
// - Control bits 15-5 read as zero.
// - Timer 0 count readable and writable.
// - Timer 1 count readable and writable.
// - Vector reads zero with nothing pending.
// - Vector codes 02h, 04h, 06h, ready highest.
// - Vector codes 08h, 0Ah, 0Ch for remaining flags.
// - Lower code wins; 0Eh reserved, lowest.
// - Written 12-bit binary reads back as BCD.
module rtp_prescale_timers
    import rtp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register bus
    input wire rtpAxiReq_t axiReq,
    output rtpAxiRsp_t axiRsp,
    // Counter clock tick and other event sources
    input wire logic tickIn,
    input wire rtpSrcEvt_t srcEvt,
    // Low-power control
    input wire logic deepSleep,
    input wire logic deepSleepIoLock,
    // Requests
    output logic irq,
    output logic wakeReq
);
    // Reserved code never produced; kept so the table spans every code
    localparam logic [`RTP_ST_W:0][15:0] VEC_TAB = {`RTP_VEC_RSVD, `RTP_VEC_OSC, `RTP_VEC_PS1,
        `RTP_VEC_PS0, `RTP_VEC_ALARM, `RTP_VEC_INTV, `RTP_VEC_READY};

    rtpState_t st_ff;
    rtpState_t nxt_st;
    logic wrFire;
    logic rdFire;
    logic wrOk;
    logic rdOk;
    logic entry;
    logic b2bWr;
    logic [31:0] rdData;
    logic [15:0] bcdValue;
    logic [15:0] vecCode;
    logic [`RTP_ST_W-1:0] vecSel;
    logic [`RTP_ST_W-1:0] vecClr;
    logic [`RTP_ST_W-1:0] clrVec;
    logic [`RTP_ST_W-1:0] evtVec;
    logic [`RTP_ST_W-1:0] effFlag;
    logic [`RTP_ST_W-1:0] effEn;
    logic [`RTP_ST_W-1:0] pending;
    logic [`RTP_NTIMER-1:0][2:0] effSel;
    logic [`RTP_NTIMER-1:0][7:0] tickCount;
    logic [`RTP_NTIMER-1:0] tickEvt;
    logic [`RTP_NTIMER-1:0] cntLoad;

    // ----------------------------------------
    // Bus handshakes
    // ----------------------------------------
    // Write waits for a free response slot so bresp is never overwritten
    assign wrFire = st_ff.awHave && st_ff.wHave && !st_ff.rsp.bvalid;
    assign rdFire = axiReq.arvalid && st_ff.rsp.arready;
    assign entry = deepSleep && !st_ff.sleepPrev;
    assign b2bWr = wrFire && (st_ff.awAddr == `RTP_OFF_B2B) && (&st_ff.wStrb[1:0]);

    // ----------------------------------------
    // Timers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `RTP_NTIMER; g++)
        begin : gTimer
            assign cntLoad[g] = wrFire && st_ff.wStrb[0]
                && (st_ff.awAddr == `RTP_OFF_CNT0 + ((g == 0) ? 8'h00 : `RTP_CH_STEP));
            rtp_prescaler uTick (
                .mclk(mclk),
                .nrst(nrst),
                .tickIn(tickIn),
                .intervalSel(effSel[g]),
                .load(cntLoad[g]),
                .loadValue(st_ff.wData[7:0]),
                .tickCount(tickCount[g]),
                .intervalEvt(tickEvt[g])
            );
        end
    endgenerate

    rtp_binary_to_decimal_converter uBcd (
        .mclk(mclk),
        .nrst(nrst),
        .wr(b2bWr),
        .binValue(st_ff.wData[11:0]),
        .bcdValue(bcdValue)
    );

    // ----------------------------------------
    // Effective settings, events and vector
    // ----------------------------------------
    always_comb
    begin
        effFlag = st_ff.flag;
        effEn = st_ff.en;
        evtVec = '0;
        evtVec[`RTP_ST_READY] = srcEvt.clockReady;
        evtVec[`RTP_ST_INTV] = srcEvt.intervalEvt;
        evtVec[`RTP_ST_ALARM] = srcEvt.userAlarm;
        evtVec[`RTP_ST_OSC] = srcEvt.oscFail;
        for (int t = 0; t < `RTP_NTIMER; t++)
        begin
            evtVec[`RTP_ST_PS0 + t] = tickEvt[t];
            // Registers are lost in deep sleep; retained copy steers until unlock
            effSel[t] = st_ff.hold ? st_ff.rtn[t].sel : st_ff.sel[t];
            if (st_ff.hold)
            begin
                effFlag[`RTP_ST_PS0 + t] = st_ff.rtn[t].fg;
                effEn[`RTP_ST_PS0 + t] = st_ff.rtn[t].ie;
            end
        end
        pending = effFlag & effEn;
        vecCode = `RTP_VEC_NONE;
        vecSel = '0;
        // Walk downward so the lowest pending index wins
        for (int i = `RTP_ST_W - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                vecCode = VEC_TAB[i];
                vecSel = '0;
                vecSel[i] = 1'b1;
            end
        end
        vecClr = (rdFire && axiReq.araddr == `RTP_OFF_VEC) ? vecSel : '0;
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb
    begin
        rdData = 32'h0000_0000;
        rdOk = 1'b1;
        case (axiReq.araddr)
            `RTP_OFF_CTL0:
                rdData[4:0] = {st_ff.sel[0], st_ff.en[`RTP_ST_PS0], st_ff.flag[`RTP_ST_PS0]};
            `RTP_OFF_CTL1:
                rdData[4:0] = {st_ff.sel[1], st_ff.en[`RTP_ST_PS1], st_ff.flag[`RTP_ST_PS1]};
            `RTP_OFF_CNT0:
                rdData[7:0] = tickCount[0];
            `RTP_OFF_CNT1:
                rdData[7:0] = tickCount[1];
            `RTP_OFF_VEC:
                rdData[15:0] = vecCode;
            `RTP_OFF_B2B:
                rdData[15:0] = bcdValue;
            `RTP_OFF_STAT:
                rdData[`RTP_ST_W-1:0] = st_ff.flag;
            `RTP_OFF_IEN:
                rdData[`RTP_ST_W-1:0] = st_ff.en;
            `RTP_OFF_CLR:
                rdData = 32'h0000_0000;
            default:
                rdOk = 1'b0;
        endcase
    end

    always_comb
    begin
        case (st_ff.awAddr)
            `RTP_OFF_CTL0, `RTP_OFF_CTL1, `RTP_OFF_CNT0, `RTP_OFF_CNT1, `RTP_OFF_VEC,
            `RTP_OFF_B2B, `RTP_OFF_STAT, `RTP_OFF_CLR, `RTP_OFF_IEN:
                wrOk = 1'b1;
            default:
                wrOk = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        clrVec = vecClr;
        if (axiReq.awvalid && st_ff.rsp.awready)
        begin
            nxt_st.awHave = 1'b1;
            nxt_st.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && st_ff.rsp.wready)
        begin
            nxt_st.wHave = 1'b1;
            nxt_st.wData = axiReq.wdata;
            nxt_st.wStrb = axiReq.wstrb;
        end
        if (wrFire)
        begin
            nxt_st.awHave = 1'b0;
            nxt_st.wHave = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp = wrOk ? `RTP_RESP_OKAY : `RTP_RESP_SLVERR;
        end
        else if (st_ff.rsp.bvalid && axiReq.bready)
            nxt_st.rsp.bvalid = 1'b0;
        if (rdFire)
        begin
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rdata = rdData;
            nxt_st.rsp.rresp = rdOk ? `RTP_RESP_OKAY : `RTP_RESP_SLVERR;
        end
        else if (st_ff.rsp.rvalid && axiReq.rready)
            nxt_st.rsp.rvalid = 1'b0;

        // Register writes; read-only offsets take the write and ignore it
        if (wrFire && st_ff.wStrb[0])
        begin
            for (int t = 0; t < `RTP_NTIMER; t++)
            begin
                if (st_ff.awAddr == `RTP_OFF_CTL0 + (t[0] ? `RTP_CH_STEP : 8'h00))
                begin
                    nxt_st.sel[t] = st_ff.wData[`RTP_CTL_SEL_HI:`RTP_CTL_SEL_LO];
                    nxt_st.en[`RTP_ST_PS0 + t] = st_ff.wData[`RTP_CTL_IE];
                    nxt_st.flag[`RTP_ST_PS0 + t] = st_ff.wData[`RTP_CTL_FG];
                end
            end
            if (st_ff.awAddr == `RTP_OFF_IEN)
                nxt_st.en = st_ff.wData[`RTP_ST_W-1:0];
            if (st_ff.awAddr == `RTP_OFF_CLR)
                clrVec = clrVec | st_ff.wData[`RTP_ST_W-1:0];
        end

        // Deep-sleep entry: save settings, then the live registers are lost
        if (entry)
        begin
            for (int t = 0; t < `RTP_NTIMER; t++)
            begin
                nxt_st.rtn[t].sel = nxt_st.sel[t];
                nxt_st.rtn[t].ie = nxt_st.en[`RTP_ST_PS0 + t];
                nxt_st.rtn[t].fg = nxt_st.flag[`RTP_ST_PS0 + t];
            end
            nxt_st.sel = '0;
            nxt_st.en = '0;
            nxt_st.flag = '0;
        end
        // Software relies on rewriting settings before it drops the lock
        nxt_st.hold = entry || (st_ff.hold && (deepSleep || deepSleepIoLock));

        // Set beats clear when both land in one cycle
        nxt_st.flag = (nxt_st.flag & ~clrVec) | evtVec;
        for (int t = 0; t < `RTP_NTIMER; t++)
        begin
            nxt_st.rtn[t].fg = (nxt_st.rtn[t].fg & ~clrVec[`RTP_ST_PS0 + t]) | tickEvt[t];
        end
        nxt_st.sleepPrev = deepSleep;

        nxt_st.irq = |pending;
        nxt_st.wake = deepSleep && effEn[`RTP_ST_PS1] && effFlag[`RTP_ST_PS1];

        nxt_st.rsp.awready = !nxt_st.awHave;
        nxt_st.rsp.wready = !nxt_st.wHave;
        nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign axiRsp = st_ff.rsp;
    assign irq = st_ff.irq;
    assign wakeReq = st_ff.wake;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    property p_irqOn;
        st_ff.flag[`RTP_ST_PS0] && st_ff.en[`RTP_ST_PS0] && !st_ff.hold |=> irq;
    endproperty
    a_irqOn: assert property (p_irqOn) else $error("enabled flag did not raise irq");

    property p_irqOff;
        !(|pending) |=> !irq;
    endproperty
    a_irqOff: assert property (p_irqOff) else $error("irq without enabled flag");

    property p_vecNone;
        rdFire && axiReq.araddr == `RTP_OFF_VEC && !(|pending)
            |=> axiRsp.rvalid && axiRsp.rdata == 32'h0000_0000;
    endproperty
    a_vecNone: assert property (p_vecNone) else $error("vector not zero when idle");

    property p_vecTop;
        rdFire && axiReq.araddr == `RTP_OFF_VEC && pending[`RTP_ST_READY]
            |=> axiRsp.rdata[15:0] == `RTP_VEC_READY;
    endproperty
    a_vecTop: assert property (p_vecTop) else $error("ready source not top priority");

    property p_vecPs1;
        rdFire && axiReq.araddr == `RTP_OFF_VEC && pending[`RTP_ST_PS1] && pending[`RTP_ST_PS1-1:0] == '0
            |=> axiRsp.rdata[15:0] == `RTP_VEC_PS1;
    endproperty
    a_vecPs1: assert property (p_vecPs1) else $error("timer 1 vector code wrong");

    property p_vecClr;
        rdFire && axiReq.araddr == `RTP_OFF_VEC && pending[`RTP_ST_READY] && !evtVec[`RTP_ST_READY]
            |=> !st_ff.flag[`RTP_ST_READY];
    endproperty
    a_vecClr: assert property (p_vecClr) else $error("vector read did not clear flag");

    property p_resv;
        rdFire && (axiReq.araddr == `RTP_OFF_CTL0 || axiReq.araddr == `RTP_OFF_CTL1)
            |=> axiRsp.rdata[31:5] == '0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved control bits not zero");

    property p_evtSet;
        tickEvt[0] && !entry |=> st_ff.flag[`RTP_ST_PS0];
    endproperty
    a_evtSet: assert property (p_evtSet) else $error("interval event lost");

    property p_hold;
        st_ff.hold && deepSleepIoLock && !entry |=> st_ff.hold && $stable(st_ff.rtn[1].sel);
    endproperty
    a_hold: assert property (p_hold) else $error("retained settings dropped under lock");

    property p_wake;
        (st_ff.hold && st_ff.rtn[1].ie && tickEvt[1] && deepSleep) ##1 deepSleep |=> wakeReq;
    endproperty
    a_wake: assert property (p_wake) else $error("timer 1 event did not wake");

    property p_bhold;
        axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
endmodule

// file: rtp_prescale_timers_test.sv
// Self-checking bench for the prescale timers, interrupt vector and converter.
// Assumes rtp_pkg and rtp_regs.svh are compiled first; drives every input itself.
`timescale 1ns/1ps
`include "rtp_regs.svh"
module rtp_prescale_timers_test;
import rtp_pkg::*;
logic mclk;
logic nrst;
logic tickIn;
logic deepSleep;
logic deepSleepIoLock;
logic irq;
logic wakeReq;
rtpAxiReq_t axiReq;
rtpAxiRsp_t axiRsp;
rtpSrcEvt_t srcEvt;
int failCount = 0;
int cmpCount = 0;
logic [31:0] rnd = 32'h00000060;
logic [31:0] rdat;
logic [1:0] resp;
logic [11:0] bval;
logic [7:0] cval;
logic [3:0] strb = 4'hF;

rtp_prescale_timers rtp_prescale_timers_inst (
    .mclk(mclk),
    .nrst(nrst),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .tickIn(tickIn),
    .srcEvt(srcEvt),
    .deepSleep(deepSleep),
    .deepSleepIoLock(deepSleepIoLock),
    .irq(irq),
    .wakeReq(wakeReq)
);

initial
begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
end

// ----------------------------------------
// Helpers
// ----------------------------------------
function logic [31:0] nextRand();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
endfunction

function automatic logic [15:0] toBcd(input logic [11:0] b);
    int v;
    v = b;
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
endfunction

task automatic chkVal(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e)
    begin
        failCount++;
        $display("ERROR %s expected %h seen %h", n, e, g);
    end
endtask

task automatic chkBit(input string n, input logic e, input logic g);
    cmpCount++;
    if (g !== e)
    begin
        failCount++;
        $display("ERROR %s expected %b seen %b", n, e, g);
    end
endtask

task automatic endTest(input string n);
    $display("test %s done", n);
endtask

task automatic waitC(input int n);
    repeat (n) @(posedge mclk);
endtask

// ----------------------------------------
// Bus and stimulus tasks
// ----------------------------------------
// Address and data are released each on its own ready; the response follows both
task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge mclk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= strb;
    axiReq.bready <= 1'b1;
    while (!(aw && w))
    begin
        @(posedge mclk);
        if (!aw && axiRsp.awready === 1'b1)
        begin
            aw = 1;
            axiReq.awvalid <= 1'b0;
        end
        if (!w && axiRsp.wready === 1'b1)
        begin
            w = 1;
            axiReq.wvalid <= 1'b0;
        end
    end
    do @(posedge mclk); while (axiRsp.bvalid !== 1'b1);
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
endtask

task automatic axRd(input logic [7:0] a);
    @(posedge mclk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do @(posedge mclk); while (axiRsp.arready !== 1'b1);
    axiReq.arvalid <= 1'b0;
    do @(posedge mclk); while (axiRsp.rvalid !== 1'b1);
    rdat = axiRsp.rdata;
    resp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
endtask

task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string n);
    axRd(a);
    chkVal(n, e, rdat);
endtask

task automatic tick(input int n);
    repeat (n)
    begin
        @(posedge mclk);
        tickIn <= 1'b1;
        @(posedge mclk);
        tickIn <= 1'b0;
    end
endtask

task automatic pulse(input rtpSrcEvt_t e);
    @(posedge mclk);
    srcEvt <= e;
    @(posedge mclk);
    srcEvt <= '0;
endtask

task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask

// ----------------------------------------
// Watchdog
// ----------------------------------------
// Whole sequence needs about 2600 cycles; limit leaves wide margin
initial
begin
    repeat (20000) @(posedge mclk);
    failCount++;
    $display("ERROR watchdog expected done seen timeout");
    tallyAndFinish();
end

// ----------------------------------------
// Main sequence
// ----------------------------------------
initial
begin
    axiReq = '0;
    srcEvt = '0;
    tickIn = 1'b0;
    deepSleep = 1'b0;
    deepSleepIoLock = 1'b0;
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rdChk(8'(i * 4), 32'h0, "reset value");
    axRd(8'h24);
    chkVal("unmapped read resp", 32'(`RTP_RESP_SLVERR), 32'(resp));
    chkVal("unmapped read data", 32'h0, rdat);
    axWr(8'h24, 32'h0000FFFF);
    chkVal("unmapped write resp", 32'(`RTP_RESP_SLVERR), 32'(resp));
    endTest("reset");
    for (int t = 0; t < 2; t++)
    begin
        axWr(`RTP_OFF_CTL0 + 8'(t * 4), 32'hFFFFFFFE);
        rdChk(`RTP_OFF_CTL0 + 8'(t * 4), 32'h0000001E, "control reserved");
    end
    endTest("reserved");
    // Each code checked one tick short of its interval and exactly on it
    for (int t = 0; t < 2; t++)
    begin
        for (int s = 0; s < 8; s++)
        begin
            axWr(`RTP_OFF_CTL0 + 8'(t * 4), 32'(s << 2));
            axWr(`RTP_OFF_CNT0 + 8'(t * 4), 32'h0);
            tick((1 << (s + 1)) - 1);
            rdChk(`RTP_OFF_CTL0 + 8'(t * 4), 32'(s << 2), "flag early");
            tick(1);
            rdChk(`RTP_OFF_CTL0 + 8'(t * 4), 32'((s << 2) | 1), "flag set");
            rdChk(`RTP_OFF_CNT0 + 8'(t * 4), 32'((1 << (s + 1)) & 8'hFF), "count");
        end
        cval = 8'(nextRand());
        axWr(`RTP_OFF_CNT0 + 8'(t * 4), {nextRand() & 32'hFFFFFF00} | 32'(cval));
        tick(3);
        rdChk(`RTP_OFF_CNT0 + 8'(t * 4), 32'(8'(cval + 8'h03)), "count reload");
    end
    endTest("interval");
    axWr(`RTP_OFF_CTL1, 32'h0);
    axWr(`RTP_OFF_CTL0, 32'h1);
    waitC(3);
    chkBit("irq masked", 1'b0, irq);
    axWr(`RTP_OFF_CTL0, 32'h3);
    waitC(3);
    chkBit("irq enabled", 1'b1, irq);
    rdChk(`RTP_OFF_VEC, 32'(`RTP_VEC_PS0), "vector timer0");
    waitC(3);
    chkBit("irq after vector", 1'b0, irq);
    rdChk(`RTP_OFF_CTL0, 32'h2, "flag cleared");
    endTest("irq");
    axWr(`RTP_OFF_IEN, 32'h3F);
    pulse('{clockReady: 1'b1, intervalEvt: 1'b1, userAlarm: 1'b1, oscFail: 1'b1});
    axWr(`RTP_OFF_CTL0, 32'h3);
    axWr(`RTP_OFF_CTL1, 32'h3);
    rdChk(`RTP_OFF_STAT, 32'h3F, "status all");
    for (int k = 1; k < 7; k++) rdChk(`RTP_OFF_VEC, 32'(2 * k), "vector order");
    rdChk(`RTP_OFF_VEC, 32'(`RTP_VEC_NONE), "vector empty");
    axWr(`RTP_OFF_VEC, 32'h0000FFFF);
    chkVal("vector write resp", 32'(`RTP_RESP_OKAY), 32'(resp));
    axWr(`RTP_OFF_IEN, 32'h3E);
    pulse('{clockReady: 1'b1, intervalEvt: 1'b0, userAlarm: 1'b0, oscFail: 1'b1});
    waitC(3);
    chkBit("irq osc", 1'b1, irq);
    rdChk(`RTP_OFF_VEC, 32'(`RTP_VEC_OSC), "vector masked ready");
    rdChk(`RTP_OFF_VEC, 32'(`RTP_VEC_NONE), "vector disabled only");
    rdChk(`RTP_OFF_STAT, 32'h1, "status sticky");
    axWr(`RTP_OFF_CLR, 32'h3F);
    rdChk(`RTP_OFF_STAT, 32'h0, "status cleared");
    endTest("vector");
    for (int i = 0; i < 10; i++)
    begin
        bval = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'(nextRand());
        axWr(`RTP_OFF_B2B, 32'(bval));
        rdChk(`RTP_OFF_B2B, 32'(toBcd(bval)), "bcd");
    end
    // Converter needs both low byte lanes; a partial write leaves it alone
    strb = 4'hE;
    axWr(`RTP_OFF_B2B, 32'h00000123);
    chkVal("partial write resp", 32'(`RTP_RESP_OKAY), 32'(resp));
    strb = 4'hF;
    rdChk(`RTP_OFF_B2B, 32'(toBcd(bval)), "bcd partial write");
    endTest("bcd");
    axWr(`RTP_OFF_IEN, 32'h0);
    axWr(`RTP_OFF_CTL1, 32'h2);
    @(posedge mclk);
    deepSleep <= 1'b1;
    deepSleepIoLock <= 1'b1;
    waitC(3);
    rdChk(`RTP_OFF_CTL1, 32'h0, "control lost");
    tick(2);
    waitC(3);
    chkBit("wake", 1'b1, wakeReq);
    chkBit("irq retained", 1'b1, irq);
    @(posedge mclk);
    deepSleep <= 1'b0;
    waitC(3);
    chkBit("wake after exit", 1'b0, wakeReq);
    chkBit("irq held by lock", 1'b1, irq);
    // Settings rewritten before the lock is let go
    axWr(`RTP_OFF_CTL1, 32'h3);
    @(posedge mclk);
    deepSleepIoLock <= 1'b0;
    waitC(3);
    rdChk(`RTP_OFF_CTL1, 32'h3, "control rewritten");
    chkBit("irq after unlock", 1'b1, irq);
    axWr(`RTP_OFF_CTL1, 32'h0);
    waitC(3);
    chkBit("irq cleared", 1'b0, irq);
    endTest("deep sleep");
    tallyAndFinish();
end
endmodule

// file: rtp_prescaler.sv
// One 8-bit prescale counter with selectable interval event.
// Assumes tickIn and load come from logic on mclk.
`timescale 1ns/1ps
`include "rtp_regs.svh"
module rtp_prescaler
    import rtp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Control
    input wire logic tickIn,
    input wire logic [2:0] intervalSel,
    input wire logic load,
    input wire logic [7:0] loadValue,
    // Status
    output logic [7:0] tickCount,
    output logic intervalEvt
);
    rtpPreState_t st_ff;
    rtpPreState_t nxt_st;
    logic [7:0] mask;

    always_comb
    begin
        mask = 8'hFF >> (3'd7 - intervalSel);
        nxt_st = st_ff;
        nxt_st.evt = 1'b0;
        if (load)
            nxt_st.cnt = loadValue;
        else if (tickIn)
        begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
            // Event when the low sel+1 bits roll over
            nxt_st.evt = ((st_ff.cnt & mask) == mask);
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tickCount = st_ff.cnt;
    assign intervalEvt = st_ff.evt;
endmodule

// file: rtp_regs.svh
// Register offsets, field positions and vector codes of the prescale timer block.
// Definitions only; included by the package and by every module file.
`ifndef RTP_REGS_SVH
`define RTP_REGS_SVH
// ----------------------------------------
// Bus
// ----------------------------------------
`define RTP_AW 8
`define RTP_RESP_OKAY 2'h0
`define RTP_RESP_SLVERR 2'h2
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RTP_OFF_CTL0 8'h00
`define RTP_OFF_CTL1 8'h04
`define RTP_OFF_CNT0 8'h08
`define RTP_OFF_CNT1 8'h0C
`define RTP_OFF_VEC 8'h10
`define RTP_OFF_B2B 8'h14
`define RTP_OFF_STAT 8'h18
`define RTP_OFF_CLR 8'h1C
`define RTP_OFF_IEN 8'h20
`define RTP_CH_STEP 8'h04
// ----------------------------------------
// Control fields and status bits
// ----------------------------------------
`define RTP_CTL_FG 0
`define RTP_CTL_IE 1
`define RTP_CTL_SEL_LO 2
`define RTP_CTL_SEL_HI 4
`define RTP_NTIMER 2
`define RTP_ST_READY 0
`define RTP_ST_INTV 1
`define RTP_ST_ALARM 2
`define RTP_ST_PS0 3
`define RTP_ST_PS1 4
`define RTP_ST_OSC 5
`define RTP_ST_W 6
// ----------------------------------------
// Vector codes
// ----------------------------------------
`define RTP_VEC_NONE 16'h0000
`define RTP_VEC_READY 16'h0002
`define RTP_VEC_INTV 16'h0004
`define RTP_VEC_ALARM 16'h0006
`define RTP_VEC_PS0 16'h0008
`define RTP_VEC_PS1 16'h000A
`define RTP_VEC_OSC 16'h000C
`define RTP_VEC_RSVD 16'h000E
`endif
